// [clk_ratio_cfg_pkg.sv]
// package of constants for the reset-sampled clock ratio configuration block
// assumes nothing beyond a SystemVerilog compiler
package clk_ratio_cfg_pkg;

   // strap vector layout: core code in the upper three bits, memory code below
   localparam int STRAP_W        = 6;
   localparam int CODE_W         = 3;
   localparam int CORE_CODE_LSB  = 3;
   localparam int MEM_CODE_LSB   = 0;

   // core to platform ratio in half steps (ratio times two)
   localparam logic [3:0] CORE_X2_NONE = 4'h0;
   localparam logic [3:0] CORE_X2_1P5  = 4'h3;
   localparam logic [3:0] CORE_X2_2P0  = 4'h4;
   localparam logic [3:0] CORE_X2_2P5  = 4'h5;
   localparam logic [3:0] CORE_X2_3P0  = 4'h6;
   localparam logic [3:0] CORE_X2_3P5  = 4'h7;

   // memory data rate to reference clock multipliers
   localparam logic [3:0] MEM_MULT_NONE = 4'h0;
   localparam logic [3:0] MEM_MULT_3    = 4'h3;
   localparam logic [3:0] MEM_MULT_4    = 4'h4;
   localparam logic [3:0] MEM_MULT_6    = 4'h6;
   localparam logic [3:0] MEM_MULT_8    = 4'h8;
   localparam logic [3:0] MEM_MULT_10   = 4'hA;

   // register port
   localparam int          ADDR_W       = 2;
   localparam int          DATA_W       = 32;
   localparam logic [1:0]  STATUS_ADDR  = 2'h0;
   localparam logic [1:0]  CONTROL_ADDR = 2'h1;
   localparam int          ST_CORE_LSB  = 0;
   localparam int          ST_MEM_LSB   = 3;
   localparam int          ST_ASYNC     = 6;
   localparam int          ST_CORE_OK   = 7;
   localparam int          ST_MEM_OK    = 8;
   localparam int          ST_DONE      = 9;
   localparam int          CT_RUN       = 0;
   localparam logic        CT_RUN_RST   = 1'b1;

   // strap reset values: an open pin reads high, the default setting
   localparam logic [5:0]  STRAP_RST    = 6'h3F;
   localparam logic        MODE_RST     = 1'b1;

endpackage

// [sync2.sv]
// two flip-flop synchroniser for a bus of independent levels
// assumes each bit is a slow level; no relation between bits is kept
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int          W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= RST;
         q       <= RST;
      end else if (ce) begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule
`default_nettype wire

// [clk_ratio_cfg.sv]
// reset-sampled clock ratio configuration: strap capture, ratio decode, memory clock mode
// assumes CLOCK is the platform bus clock; straps and hard reset arrive from pins
//
// Function
// RULE1: core to platform ratio taken at power-up from three strap inputs
// RULE2: core codes 011..111 give 3:2,2:1,5:2,3:1,7:2; 000..010 reserved
// RULE3: both memory complexes run synchronous or asynchronous per reset configuration
// RULE4: memory controller clock equals memory data rate, not the reference clock
// RULE5: synchronous mode clocks memory buses at half the platform clock
// RULE6: default data rate is platform clock (sync) or memory PLL output (async)
// RULE7: asynchronous mode ratio sets data rate against the reference clock
// RULE8: memory codes 000..100 give 3,4,6,8,10 to one; others undefined
// RULE9: board supplies memory reference clock only when asynchronous mode selected
// RULE10: both memory controllers always share one clock mode
// RULE11: board must not pull sampled output pins low during power-on reset
// RULE12: board holds test-select input at required level during reset configuration
// RULE13: pins are inputs during hard reset, latched at release, then outputs
// RULE14: high strap level selects the default setting
// RULE15: latched selections stay constant until the next hard reset; the code also reloads them at NRST and relatches at its release
`timescale 1ns/1ps
`default_nettype none
module clk_ratio_cfg
   import clk_ratio_cfg_pkg::*;
(
   input  wire logic              CLOCK,
   input  wire logic              NRST,
   input  wire logic              CE,
   input  wire logic              HARD_RESET_N,
   input  wire logic [STRAP_W-1:0] CFG_PIN_IN,
   output var  logic [STRAP_W-1:0] CFG_PIN_OUT,
   output var  logic [STRAP_W-1:0] CFG_PIN_OE,
   input  wire logic [STRAP_W-1:0] FUNC_OUT,
   input  wire logic              MEM_MODE_CFG,
   output var  logic [3:0]        CORE_RATIO_X2,
   output var  logic              CORE_RATIO_OK,
   output var  logic [3:0]        MEM_PLL_MULT,
   output var  logic              MEM_RATIO_OK,
   output var  logic              MEM_PLL_EN,
   output var  logic [1:0]        MEM_CLK_SEL,
   output var  logic              MEM_REF_CLK_REQ,
   output var  logic              MEM_BUS_CLK_EN,
   output var  logic              CFG_DONE,
   input  wire logic [ADDR_W-1:0] ADDR,
   input  wire logic [DATA_W-1:0] WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output var  logic [DATA_W-1:0] RDATA
);

   ////////////////////////////////////////////////////////////////////////////////
   // decode functions

   function automatic logic [3:0] core_x2(input logic [CODE_W-1:0] c);
      case (c)
         3'h3:    core_x2 = CORE_X2_1P5;
         3'h4:    core_x2 = CORE_X2_2P0;
         3'h5:    core_x2 = CORE_X2_2P5;
         3'h6:    core_x2 = CORE_X2_3P0;
         3'h7:    core_x2 = CORE_X2_3P5;
         default: core_x2 = CORE_X2_NONE;
      endcase
   endfunction

   function automatic logic [3:0] mem_mult(input logic [CODE_W-1:0] c);
      case (c)
         3'h0:    mem_mult = MEM_MULT_3;
         3'h1:    mem_mult = MEM_MULT_4;
         3'h2:    mem_mult = MEM_MULT_6;
         3'h3:    mem_mult = MEM_MULT_8;
         3'h4:    mem_mult = MEM_MULT_10;
         default: mem_mult = MEM_MULT_NONE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers

   logic       rst_meta_ff;
   logic       rst_n;
   logic       ce;
   logic       hrst_s;
   logic [STRAP_W-1:0] strap_s;
   logic       mode_s;

   assign ce = CE;

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         rst_meta_ff <= 1'b0;
         rst_n       <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n       <= rst_meta_ff;
      end
   end

   sync2 #(.W(STRAP_W + 2), .RST({STRAP_RST, MODE_RST, 1'b0})) u_sync (
      .clk   (CLOCK),
      .rst_n (rst_n),
      .ce    (ce),
      .d     ({CFG_PIN_IN, MEM_MODE_CFG, HARD_RESET_N}),
      .q     ({strap_s, mode_s, hrst_s})
   );

   ////////////////////////////////////////////////////////////////////////////////
   // capture at hard reset release

   logic              hrst_d_ff;
   logic              latch_pulse;
   logic [CODE_W-1:0] core_code_ff;
   logic [CODE_W-1:0] mem_code_ff;
   logic              mem_async_ff;
   logic              done_ff;
   logic              oe_ff;
   logic [STRAP_W-1:0] pin_out_ff;

   assign latch_pulse = hrst_s && !hrst_d_ff;

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         hrst_d_ff    <= 1'b0;
         core_code_ff <= STRAP_RST[CORE_CODE_LSB +: CODE_W];
         mem_code_ff  <= STRAP_RST[MEM_CODE_LSB +: CODE_W];
         mem_async_ff <= !MODE_RST;
         done_ff      <= 1'b0;
         oe_ff        <= 1'b0;
         pin_out_ff   <= '0;
      end else if (ce) begin
         hrst_d_ff  <= hrst_s;
         pin_out_ff <= FUNC_OUT;
         oe_ff      <= hrst_s && hrst_d_ff;                          // RULE13
         if (!hrst_s) begin
            done_ff <= 1'b0;
         end else if (latch_pulse) begin                              // RULE15
            core_code_ff <= strap_s[CORE_CODE_LSB +: CODE_W];        // RULE1
            mem_code_ff  <= strap_s[MEM_CODE_LSB +: CODE_W];         // RULE8
            mem_async_ff <= !mode_s;                                  // RULE14
            done_ff      <= 1'b1;
         end
      end
   end

   assign CFG_PIN_OUT = pin_out_ff;
   assign CFG_PIN_OE  = {STRAP_W{oe_ff}};                            // RULE13

   ////////////////////////////////////////////////////////////////////////////////
   // decoded selections

   logic [3:0] core_x2_w;
   logic [3:0] mem_mult_w;
   logic       run_ff;
   logic       half_ff;
   logic       sync_run;

   assign core_x2_w       = core_x2(core_code_ff);                   // RULE2
   assign mem_mult_w      = mem_mult(mem_code_ff);                   // RULE8
   assign CORE_RATIO_X2   = core_x2_w;
   assign CORE_RATIO_OK   = done_ff && (core_x2_w != CORE_X2_NONE);
   assign MEM_RATIO_OK    = done_ff && (mem_mult_w != MEM_MULT_NONE);
   assign MEM_PLL_MULT    = mem_async_ff ? mem_mult_w : MEM_MULT_NONE; // RULE7
   assign MEM_PLL_EN      = done_ff && mem_async_ff;                  // RULE6
   assign MEM_CLK_SEL     = {2{mem_async_ff}};                        // RULE4 RULE10
   assign MEM_REF_CLK_REQ = mem_async_ff;                             // RULE9
   assign CFG_DONE        = done_ff;
   assign sync_run        = done_ff && run_ff && !mem_async_ff;       // RULE3
   assign MEM_BUS_CLK_EN  = half_ff;

   // memory bus clock enable toggles each platform cycle in synchronous mode while run is set: half rate
   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         half_ff <= 1'b0;
      end else if (ce) begin
         half_ff <= sync_run && !half_ff;                             // RULE5
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register port

   logic              wr_ctl;
   logic              rd_status;
   logic              rd_control;
   logic [DATA_W-1:0] status_w;
   logic [DATA_W-1:0] nxt_rdata;
   logic [DATA_W-1:0] rdata_ff;

   assign wr_ctl     = WR && (ADDR == CONTROL_ADDR);
   assign rd_status  = RD && (ADDR == STATUS_ADDR);
   assign rd_control = RD && (ADDR == CONTROL_ADDR);

   always_comb begin
      status_w                                = '0;
      status_w[ST_CORE_LSB +: CODE_W]         = core_code_ff;
      status_w[ST_MEM_LSB +: CODE_W]          = mem_code_ff;
      status_w[ST_ASYNC]                      = mem_async_ff;
      status_w[ST_CORE_OK]                    = CORE_RATIO_OK;
      status_w[ST_MEM_OK]                     = MEM_RATIO_OK;
      status_w[ST_DONE]                       = done_ff;
   end

   assign nxt_rdata = rd_status  ? status_w :
                      rd_control ? {{(DATA_W-1){1'b0}}, run_ff} : '0;

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         run_ff   <= CT_RUN_RST;
         rdata_ff <= '0;
      end else if (ce) begin
         if (wr_ctl) begin
            run_ff <= WDATA[CT_RUN];
         end
         rdata_ff <= nxt_rdata;
      end
   end

   assign RDATA = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // assertions

   pins_input_a: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE13
      (ce && !hrst_s) |=> !oe_ff)
      else $error("config pins driven during hard reset");

   core_take_a: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE1
      (ce && latch_pulse) |=> core_code_ff == $past(strap_s[CORE_CODE_LSB +: CODE_W]))
      else $error("core code not captured at release");

   core_dec_a: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE2
      (done_ff && core_code_ff == 3'h5) |-> (CORE_RATIO_X2 == 4'h5 && CORE_RATIO_OK))
      else $error("core ratio 5:2 decode wrong");

   core_rsv_a: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE2
      (core_code_ff < 3'h3) |-> !CORE_RATIO_OK)
      else $error("reserved core code accepted");

   mem_dec_a: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE8
      (done_ff && mem_async_ff && mem_code_ff == 3'h2) |-> MEM_PLL_MULT == 4'h6)
      else $error("memory ratio 6:1 decode wrong");

   mem_undef_a: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE8
      (mem_code_ff > 3'h4) |-> !MEM_RATIO_OK)
      else $error("undefined memory code accepted");

   hold_sel_a: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE15
      (done_ff && hrst_s) |=> ($stable(core_code_ff) && $stable(mem_code_ff)
                               && $stable(mem_async_ff)))
      else $error("latched selection changed without hard reset");

   half_rate_a: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE5
      (ce && MEM_BUS_CLK_EN) |=> !MEM_BUS_CLK_EN)
      else $error("memory bus enable faster than half rate");

   half_on_a: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE5
      (ce && sync_run && !MEM_BUS_CLK_EN) |=> MEM_BUS_CLK_EN)
      else $error("memory bus enable missing in synchronous mode");

   async_off_a: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE6
      mem_async_ff |-> (!MEM_BUS_CLK_EN && MEM_CLK_SEL == 2'h3))
      else $error("asynchronous mode still on platform clock");

   same_mode_a: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE10
      MEM_CLK_SEL[0] == MEM_CLK_SEL[1])
      else $error("memory controllers in different clock modes");

   default_sel_a: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE14
      (ce && latch_pulse && strap_s == STRAP_RST && mode_s)
      |=> (CORE_RATIO_X2 == 4'h7 && !mem_async_ff))
      else $error("all-high straps not default");

endmodule
`default_nettype wire

// [strap_board.sv]
// board model: strap resistors on the shared configuration pins and the mode strap
// assumes the device enables its pin drivers only after configuration is latched
`timescale 1ns/1ps
`default_nettype none
module strap_board
   import clk_ratio_cfg_pkg::*;
(
   input  wire logic [STRAP_W-1:0] strap,
   input  wire logic               mode_sync,
   input  wire logic [STRAP_W-1:0] pin_out,
   input  wire logic [STRAP_W-1:0] pin_oe,
   output var  logic [STRAP_W-1:0] pin_lvl,
   output var  logic               mode_lvl,
   output var  logic               ref_clk_on
);
   ////////////////////////////////////////////////////////////////////////////////
   // an undriven pin settles to its resistor level; open pins read high
   always_comb begin
      pin_lvl    = (pin_oe & pin_out) | (~pin_oe & strap);
      mode_lvl   = mode_sync;
      ref_clk_on = ~mode_sync;
   end
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the clock ratio configuration block
// assumes the board model drives the straps while the pin drivers are off
`timescale 1ns/1ps
`default_nettype none
module tb
   import clk_ratio_cfg_pkg::*;
;
   logic        clock, nrst, hrst_n, mode, wr, rd, ce;
   logic [5:0]  strap, func_out, s;
   logic [1:0]  addr;
   logic [31:0] wdata, rnd, rv;
   logic        m, b0;
   wire  logic [5:0]  pin_lvl, pin_out, pin_oe;
   wire  logic [3:0]  core_x2, mem_mult;
   wire  logic [1:0]  clk_sel;
   wire  logic [31:0] rdata;
   wire  logic        core_ok, mem_ok, pll_en, ref_req, bus_en, done, mode_lvl;
   int          mismatches, tests_run, seed, n;

   strap_board board (.strap(strap), .mode_sync(mode), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_lvl(pin_lvl), .mode_lvl(mode_lvl), .ref_clk_on());
   clk_ratio_cfg dut (.CLOCK(clock), .NRST(nrst), .CE(ce), .HARD_RESET_N(hrst_n),
      .CFG_PIN_IN(pin_lvl), .CFG_PIN_OUT(pin_out), .CFG_PIN_OE(pin_oe), .FUNC_OUT(func_out),
      .MEM_MODE_CFG(mode_lvl), .CORE_RATIO_X2(core_x2), .CORE_RATIO_OK(core_ok),
      .MEM_PLL_MULT(mem_mult), .MEM_RATIO_OK(mem_ok), .MEM_PLL_EN(pll_en),
      .MEM_CLK_SEL(clk_sel), .MEM_REF_CLK_REQ(ref_req), .MEM_BUS_CLK_EN(bus_en),
      .CFG_DONE(done), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [3:0] exp_core(input logic [2:0] c);
      return (c < 3'h3) ? CORE_X2_NONE : {1'b0, c};
   endfunction
   function automatic logic [3:0] exp_mult(input logic [2:0] c);
      case (c)
         3'h0: return MEM_MULT_3;
         3'h1: return MEM_MULT_4;
         3'h2: return MEM_MULT_6;
         3'h3: return MEM_MULT_8;
         3'h4: return MEM_MULT_10;
         default: return MEM_MULT_NONE;
      endcase
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reg_read(input logic [1:0] a, output logic [31:0] d);
      @(posedge clock);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd   <= 1'b0;
      @(negedge clock);
      d = rdata;
   endtask
   task automatic reg_write(input logic [1:0] a, input logic [31:0] v);
      @(posedge clock);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge clock);
      wr    <= 1'b0;
   endtask
   task automatic conclude;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // one hard reset cycle with the given straps, then checks of every latched output
   task automatic configure(input logic [5:0] sv, input logic ms);
      logic [2:0] cc, mc;
      logic       as;
      cc = sv[5:3];
      mc = sv[2:0];
      as = ~ms;
      @(posedge clock);
      hrst_n <= 1'b0;
      strap  <= sv;
      mode   <= ms;
      repeat (4) @(posedge clock);
      @(negedge clock);
      chk("oe in reset", 32'h0, {26'h0, pin_oe});
      chk("done in reset", 32'h0, {31'h0, done});
      @(posedge clock);
      hrst_n <= 1'b1;
      n = 0;
      while (done !== 1'b1 && n < 8) begin
         @(negedge clock);
         n++;
      end
      @(negedge clock);
      chk("oe after latch", 32'h3F, {26'h0, pin_oe});
      chk("core ratio", {28'h0, exp_core(cc)}, {28'h0, core_x2});
      chk("core ok", {31'h0, cc >= 3'h3}, {31'h0, core_ok});
      chk("mem mult", {28'h0, as ? exp_mult(mc) : 4'h0}, {28'h0, mem_mult});
      chk("mem ok", {31'h0, mc <= 3'h4}, {31'h0, mem_ok});
      chk("pll en", {31'h0, as}, {31'h0, pll_en});
      chk("clk sel", {30'h0, as, as}, {30'h0, clk_sel});
      chk("ref req", {31'h0, as}, {31'h0, ref_req});
      reg_read(STATUS_ADDR, rv);
      chk("status", {22'h0, 1'b1, mc <= 3'h4, cc >= 3'h3, as, mc, cc}, rv);
      if (ms) begin
         b0 = bus_en;
         @(negedge clock);
         chk("bus clk toggle", {31'h0, ~b0}, {31'h0, bus_en});
      end
      rnd = $random(seed);
      @(posedge clock);
      strap    <= ~sv;
      mode     <= ~ms;
      func_out <= rnd[5:0];
      repeat (3) @(negedge clock);
      chk("pin out", {26'h0, rnd[5:0]}, {26'h0, pin_out});
      chk("core held", {28'h0, exp_core(cc)}, {28'h0, core_x2});
      chk("mode held", {31'h0, as}, {31'h0, pll_en});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      conclude;
   end
   initial begin
      seed = 66433;
      {nrst, hrst_n, wr, rd, mode, strap, func_out, addr, wdata} = {5'h01, 12'hFC0, 34'h0};
      mismatches = 0;
      tests_run  = 0;
      ce         = 1'b1;
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      reg_read(CONTROL_ADDR, rv);
      chk("control reset", 32'h1, rv);
      @(negedge clock);
      chk("rdata idle", 32'h0, rdata);
      reg_write(2'h3, 32'hFFFFFFFF);
      reg_read(2'h3, rv);
      chk("unmapped", 32'h0, rv);
      for (int i = 0; i < 24; i++) begin
         rnd = $random(seed);
         s   = (i < 8) ? {i[2:0], i[2:0]} : rnd[5:0];
         m   = (i < 8) ? i[0] : rnd[8];
         configure(s, m);
      end
      configure(6'h3F, 1'b1);
      reg_write(CONTROL_ADDR, 32'h0);
      repeat (2) @(negedge clock);
      chk("bus clk stopped", 32'h0, {31'h0, bus_en});
      @(negedge clock);
      chk("bus clk stopped", 32'h0, {31'h0, bus_en});
      reg_read(CONTROL_ADDR, rv);
      chk("control written", 32'h0, rv);
      reg_write(CONTROL_ADDR, 32'h1);
      // clock enable low freezes the half-rate toggle
      @(posedge clock);
      ce <= 1'b0;
      repeat (2) @(negedge clock);
      b0 = bus_en;
      @(negedge clock);
      chk("bus clk frozen", {31'h0, b0}, {31'h0, bus_en});
      @(posedge clock);
      ce <= 1'b1;
      repeat (2) @(negedge clock);
      chk("bus clk resumed", {31'h0, ~b0}, {31'h0, bus_en});
      @(posedge clock);
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(negedge clock);
      chk("done after reset", 32'h0, {31'h0, done});
      repeat (3) @(negedge clock);
      chk("done relatched", 32'h1, {31'h0, done});
      conclude;
   end
endmodule
`default_nettype wire
